// File: hdl/ubpf_pkg.sv
// ubpf_pkg: register map, field positions, reset values and timing for the break/pin-function block.
// assumes a 20 MHz core clock and a 32-bit AXI4-Lite register bus.
package ubpf_pkg;
  // printed offsets are register indices; byte address is four times the index
  localparam int unsigned BRK_IDX = 'h0a;
  localparam int unsigned TAD_IDX = 'h0b;
  localparam int unsigned PFS_IDX = 'h0c;
  localparam int unsigned DIR_IDX = 'h0d;
  localparam int unsigned CFG_IDX = 'h20;
  localparam int unsigned STS_IDX = 'h21;
  localparam logic [7:0] BRK_ADDR = 8'(BRK_IDX * 4);
  localparam logic [7:0] TAD_ADDR = 8'(TAD_IDX * 4);
  localparam logic [7:0] PFS_ADDR = 8'(PFS_IDX * 4);
  localparam logic [7:0] DIR_ADDR = 8'(DIR_IDX * 4);
  localparam logic [7:0] CFG_ADDR = 8'(CFG_IDX * 4);
  localparam logic [7:0] STS_ADDR = 8'(STS_IDX * 4);
  localparam logic [15:0] BRK_RESET = 16'h0000;
  localparam logic [15:0] BRK_CONT = 16'hffff;
  localparam logic [3:0] TAD_RESET = 4'h0;
  localparam logic [9:0] PFS_RESET = 10'h300;
  localparam logic [9:0] DIR_RESET = 10'h000;
  // pin-function field positions
  localparam int PFS_RXTOG = 9;
  localparam int PFS_TXTOG = 8;
  localparam int PFS_CLKEN = 7;
  localparam int PFS_SEC_HI = 6;
  localparam int PFS_SEC_LO = 5;
  localparam int PFS_SECSEL = 4;
  localparam int PFS_POL = 3;
  localparam int PFS_MODE_HI = 2;
  // config register fields
  localparam int CFG_HDX = 0;
  localparam int CFG_BIT_LO = 8;
  localparam logic [15:0] CFG_RESET = 16'h0a00;
  // mode codes for pins 2 to 5, and pin-7 secondary codes
  localparam logic [2:0] MODE_GPIO = 3'h0;
  localparam logic [2:0] MODE_RTSCTS = 3'h1;
  localparam logic [2:0] MODE_DTRDSR = 3'h2;
  localparam logic [2:0] MODE_DE_TX = 3'h3;
  localparam logic [2:0] MODE_DE_MATCH = 3'h4;
  localparam logic [1:0] SEC_DE_TX = 2'h1;
  localparam logic [1:0] SEC_DE_MATCH = 2'h2;
  // timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned DRAIN_CHARS = 2;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [1:0] {UBPF_IDLE = 2'b00, UBPF_WAIT = 2'b01, UBPF_BREAK = 2'b11, UBPF_DRAIN = 2'b10} ubpf_brk_t;
endpackage

// File: hdl/ubpf_top.sv
// ubpf_top: tx break timer, half-duplex turnaround delay, pin-function mux and pin direction.
// assumes a uart core on aclk giving char/bit strobes; pins reach the fabric unsynchronised.
`timescale 1ns/1ns
module ubpf_top import ubpf_pkg::*; #(
  parameter int unsigned MS_COUNT = MS_CYCLES // cycles per millisecond
) (
  input wire logic aclk, // core clock, 20 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic tx_shifting, // uart core is shifting a character
  input wire logic bit_tick, // one-cycle pulse per bit time
  input wire logic char_tick, // one-cycle pulse per character time
  input wire logic tx_active, // uart transmitting (incl. stop)
  input wire logic addr_matched, // multidrop address match active
  input wire logic rx_toggle, // receive-activity toggle
  input wire logic tx_toggle, // transmit-activity toggle
  input wire logic gen_clk, // generated clock for pin 6
  input wire logic rts_flow, // auto handshake request level
  input wire logic dtr_flow, // auto handshake terminal-ready level
  input wire logic [9:0] gpio_out, // gpio output levels from set/clear logic
  input wire logic [9:0] pin_in, // raw pin levels
  output logic [9:0] pin_out, // pin drive levels
  output logic [9:0] pin_oe, // pin output enables, high drives
  output logic [9:0] pin_state, // synchronised pin levels
  output logic tx_break, // force tx line to break
  output logic xcvr_tx_dir, // half-duplex direction, high transmit
  output logic cts_seen, // synchronised clear-to-send
  output logic dsr_seen // synchronised set-ready
);
  logic [15:0] brk_cnt;
  logic [3:0] tad;
  logic [9:0] pfs;
  logic [9:0] dir;
  logic hdx_en;
  ubpf_brk_t st;
  ubpf_brk_t next_st;
  logic [$clog2(MS_COUNT)-1:0] ms_cnt;
  logic ms_tick;
  logic [1:0] drain_cnt;
  logic [3:0] tad_cnt;
  logic tad_run;
  logic [9:0] pin_m;
  logic [9:0] pin_s;
  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;

  // bus write path: address and data taken in either order
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_hold || aw_take;
  wire w_have = w_hold || w_take;
  wire [7:0] wa = aw_hold ? aw_q : s_axi_awaddr;
  wire [31:0] wd = w_hold ? w_q : s_axi_wdata;
  wire [3:0] wsb = w_hold ? ws_q : s_axi_wstrb;
  wire wr_go = aw_have && w_have && !s_axi_bvalid;
  wire wr_lo = wr_go && wsb[0];
  wire wr_hi = wr_go && wsb[1];
  wire wa_ok = (wa == BRK_ADDR) || (wa == TAD_ADDR) || (wa == PFS_ADDR) ||
               (wa == DIR_ADDR) || (wa == CFG_ADDR) || (wa == STS_ADDR);
  wire brk_wr = wr_go && (wa == BRK_ADDR) && (wsb[1:0] != 2'b00);
  wire [15:0] brk_new = {wsb[1] ? wd[15:8] : brk_cnt[15:8], wsb[0] ? wd[7:0] : brk_cnt[7:0]};

  // read decode
  wire ra_ok = (s_axi_araddr == BRK_ADDR) || (s_axi_araddr == TAD_ADDR) || (s_axi_araddr == PFS_ADDR) ||
               (s_axi_araddr == DIR_ADDR) || (s_axi_araddr == CFG_ADDR) || (s_axi_araddr == STS_ADDR);
  wire [31:0] rd_mux =
    (s_axi_araddr == BRK_ADDR) ? {16'h0000, brk_cnt} :
    (s_axi_araddr == TAD_ADDR) ? {28'h0000000, tad} :
    (s_axi_araddr == PFS_ADDR) ? {22'h000000, pfs} :
    (s_axi_araddr == DIR_ADDR) ? {22'h000000, dir} :
    (s_axi_araddr == CFG_ADDR) ? {31'h00000000, hdx_en} :
    (s_axi_araddr == STS_ADDR) ? {16'h0000, tad_run, xcvr_tx_dir, st, tx_break, pin_state, 1'b0} :
    32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h00000000;
      ws_q <= 4'h0;
    end else begin
      s_axi_awready <= !aw_have && !s_axi_bvalid && !wr_go;
      s_axi_wready <= !w_have && !s_axi_bvalid && !wr_go;
      if (aw_take) begin
        aw_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      aw_hold <= aw_have && !wr_go;
      w_hold <= w_have && !wr_go;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wa_ok ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= AXI_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= ra_ok ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tad <= TAD_RESET;
      pfs <= PFS_RESET;
      dir <= DIR_RESET;
      hdx_en <= CFG_RESET[CFG_HDX];
    end else begin
      if (wr_lo && wa == TAD_ADDR) tad <= wd[3:0];
      if (wr_lo && wa == PFS_ADDR) pfs[7:0] <= wd[7:0];
      if (wr_hi && wa == PFS_ADDR) pfs[9:8] <= wd[9:8];
      if (wr_lo && wa == DIR_ADDR) dir[7:0] <= wd[7:0];
      if (wr_hi && wa == DIR_ADDR) dir[9:8] <= wd[9:8];
      if (wr_lo && wa == CFG_ADDR) hdx_en <= wd[CFG_HDX];
    end
  end

  // millisecond tick, phased to break entry so a late start never shortens the break
  assign ms_tick = (ms_cnt == ($clog2(MS_COUNT))'(MS_COUNT - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn || brk_wr || ms_tick || st != UBPF_BREAK) begin
      ms_cnt <= '0;
    end else begin
      ms_cnt <= ms_cnt + 1'b1;
    end
  end

  // break sequencer
  wire brk_nz = (brk_cnt != BRK_RESET);
  always_comb begin
    next_st = st;
    case (st)
      UBPF_IDLE: if (brk_nz) next_st = UBPF_WAIT;
      UBPF_WAIT: begin
        if (!brk_nz) next_st = UBPF_IDLE;
        else if (!tx_shifting) next_st = UBPF_BREAK;
      end
      UBPF_BREAK: if (!brk_nz) next_st = UBPF_DRAIN;
      UBPF_DRAIN: if (brk_nz) next_st = UBPF_BREAK;
        else if (drain_cnt == 2'(DRAIN_CHARS - 1) && char_tick) next_st = UBPF_IDLE;
      default: next_st = UBPF_IDLE;
    endcase
    if (brk_wr) begin
      next_st = (brk_new == BRK_RESET) ? UBPF_IDLE :
                (st == UBPF_BREAK || st == UBPF_DRAIN) ? UBPF_BREAK : UBPF_WAIT;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= UBPF_IDLE;
      brk_cnt <= BRK_RESET;
      drain_cnt <= 2'h0;
      tx_break <= 1'b0;
    end else begin
      st <= next_st;
      if (brk_wr) begin
        brk_cnt <= brk_new;
      end else if (st == UBPF_BREAK && ms_tick && brk_nz && brk_cnt != BRK_CONT) begin
        brk_cnt <= brk_cnt - 1'b1;
      end
      drain_cnt <= (st != UBPF_DRAIN) ? 2'h0 : drain_cnt + 2'(char_tick);
      tx_break <= (next_st == UBPF_BREAK) || (next_st == UBPF_DRAIN);
    end
  end

  // half-duplex turnaround: hold transmit direction for tad bit times after tx ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tad_cnt <= 4'h0;
      tad_run <= 1'b0;
      xcvr_tx_dir <= 1'b0;
    end else if (tx_active || tx_break) begin
      tad_cnt <= tad;
      tad_run <= hdx_en;
      xcvr_tx_dir <= 1'b1;
    end else if (tad_run && tad_cnt != 4'h0) begin
      if (bit_tick) tad_cnt <= tad_cnt - 1'b1;
    end else begin
      tad_run <= 1'b0;
      xcvr_tx_dir <= 1'b0;
    end
  end

  // pin function mux
  wire [2:0] mode = pfs[PFS_MODE_HI:0];
  wire [1:0] sec = pfs[PFS_SEC_HI:PFS_SEC_LO];
  wire de_tx = xcvr_tx_dir;
  wire de_lvl_tx = pfs[PFS_POL] ? de_tx : !de_tx;
  wire de_lvl_m = pfs[PFS_POL] ? addr_matched : !addr_matched;
  wire p5_de = !pfs[PFS_SECSEL] && (mode == MODE_DE_TX || mode == MODE_DE_MATCH);
  wire p5_rts = mode == MODE_RTSCTS;
  wire p4_cts = mode == MODE_RTSCTS;
  wire p23 = mode == MODE_DTRDSR;
  wire p7_de = pfs[PFS_SECSEL] && (sec == SEC_DE_TX || sec == SEC_DE_MATCH);
  wire [9:0] alt_out = {pfs[PFS_RXTOG], pfs[PFS_TXTOG], p7_de, pfs[PFS_CLKEN], p5_de || p5_rts, 1'b0,
                        1'b0, p23, 1'b0, 1'b0};
  wire [9:0] alt_in = {5'h00, p4_cts, p23, 3'h0};
  wire [9:0] alt_any = alt_out | alt_in;
  wire [9:0] alt_val = {rx_toggle, tx_toggle,
                        (sec == SEC_DE_TX) ? de_lvl_tx : de_lvl_m,
                        gen_clk,
                        p5_rts ? !rts_flow : (mode == MODE_DE_TX) ? de_lvl_tx : de_lvl_m,
                        1'b0, 1'b0, !dtr_flow, 1'b0, 1'b0};
  wire [9:0] next_oe = alt_out | (dir & ~alt_any);
  wire [9:0] next_out = (alt_out & alt_val) | (~alt_any & gpio_out);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_m <= 10'h000;
      pin_s <= 10'h000;
      pin_oe <= 10'h000;
      pin_out <= 10'h000;
      cts_seen <= 1'b0;
      dsr_seen <= 1'b0;
    end else begin
      pin_m <= pin_in;
      pin_s <= pin_m;
      pin_oe <= next_oe;
      pin_out <= next_out;
      cts_seen <= p4_cts && !pin_s[4];
      dsr_seen <= p23 && !pin_s[3];
    end
  end
  assign pin_state = pin_s;
endmodule // ubpf_top

// File: sim/uart_break_pin_function_ctrl_test.sv
// uart_break_pin_function_ctrl_test: self-checking bench for break, turnaround and pin mux.
// assumes 16-bit registers in the low half word; bus responses checked by a watcher.
`timescale 1ns/1ns
module uart_break_pin_function_ctrl_test import ubpf_pkg::*;;
  localparam int MS = 20;
  localparam int CHAR = 40;
  logic aclk, aresetn, awvalid, wvalid, arvalid, bready, rready, tx_shifting, bit_tick, char_tick;
  logic tx_active, addr_matched, rx_toggle, tx_toggle, gen_clk, rts_flow, dtr_flow;
  logic awready, wready, bvalid, arready, rvalid, tx_break, xcvr_tx_dir;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [9:0] gpio_out, pin_in, pin_out, pin_oe, d;
  logic [67:0] sb_q[$];
  logic [67:0] ent;
  int fail_count = 0, n_tests = 0, cyc = 0, n, i, m, ticks;
  ubpf_top #(.MS_COUNT(MS)) dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_shifting(tx_shifting), .bit_tick(bit_tick),
    .char_tick(char_tick), .tx_active(tx_active), .addr_matched(addr_matched), .rx_toggle(rx_toggle),
    .tx_toggle(tx_toggle), .gen_clk(gen_clk), .rts_flow(rts_flow), .dtr_flow(dtr_flow), .gpio_out(gpio_out),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_state(), .tx_break(tx_break),
    .xcvr_tx_dir(xcvr_tx_dir), .cts_seen(), .dsr_seen());
  ubpf_xcvr_model xcvr_u (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tmo;
    fail_count++;
    $display("[FAIL] %0t wait ran out", $time);
    wrap_up();
  endtask
  task automatic wait_lvl(ref logic s, input logic v, input int lim, output int k);
    for (k = 0; s !== v; k++) begin
      if (k >= lim) tmo();
      @(posedge aclk);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] dv, input logic [1:0] r = AXI_OKAY);
    int j;
    sb_q.push_back({34'h300000000, r, 32'h0});
    awaddr <= a;
    wdata <= {16'h0, dv};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (j = 0; j < 40; j++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (j == 40) tmo();
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] mk = '1);
    int j;
    sb_q.push_back({mk, e & mk});
    araddr <= a;
    arvalid <= 1'b1;
    for (j = 0; j < 40; j++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (j == 40) tmo();
  endtask
  always @(posedge aclk) begin
    if (rvalid === 1'b1 || bvalid === 1'b1) begin
      ent = sb_q.size() ? sb_q.pop_front() : {{34{1'b1}}, 34'bx};
      check((rvalid === 1'b1 ? {rresp, rdata} : {bresp, 32'h0}) & ent[67:34], ent[33:0]);
    end
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    bit_tick <= cyc[1:0] == 2'h3;
    char_tick <= (cyc % CHAR) == 0;
    gen_clk <= cyc[0];
    {addr_matched, rx_toggle, tx_toggle, rts_flow, dtr_flow, gpio_out} <= 15'($urandom);
  end
  initial begin
    {aresetn, awvalid, wvalid, arvalid, tx_shifting, tx_active} = '0;
    {awaddr, araddr, wdata} = '0;
    bready = 1'b1;
    rready = 1'b1;
    void'($urandom(32'h74a3aa2b));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(BRK_ADDR, 34'(BRK_RESET));
    rd(TAD_ADDR, 34'(TAD_RESET));
    rd(PFS_ADDR, 34'(PFS_RESET));
    rd(DIR_ADDR, 34'(DIR_RESET));
    rd(8'h3c, {AXI_SLVERR, 32'h0}, 34'h300000000);
    wr(8'h3c, 16'h1234, AXI_SLVERR);
    check(34'(pin_oe), 34'h300);
    $display("reset test done");
    d = 10'($urandom);
    wr(DIR_ADDR, 16'(d));
    wr(PFS_ADDR, 16'h0000);
    repeat (4) @(posedge aclk);
    check(34'(pin_oe), 34'(d));
    wr(PFS_ADDR, 16'h0380);
    repeat (4) @(posedge aclk);
    check(34'(pin_oe), 34'(d | 10'h340));
    rd(DIR_ADDR, 34'(d));
    wr(DIR_ADDR, 16'h0000);
    for (m = 0; m < 5; m++) begin
      wr(PFS_ADDR, 16'(m));
      repeat (4) @(posedge aclk);
      check(34'(pin_oe[5]), 34'(m == 1 || m == 3 || m == 4));
    end
    $display("pin function test done");
    tx_shifting <= 1'b1;
    wr(BRK_ADDR, 16'h0003);
    repeat (MS / 2) @(posedge aclk);
    check(34'(tx_break), 34'h0);
    tx_shifting <= 1'b0;
    wait_lvl(tx_break, 1'b1, MS + 4, n);
    wait_lvl(tx_break, 1'b0, 3 * MS + 3 * CHAR + 8, n);
    check(34'(n >= 3 * MS), 34'h1);
    check(34'(n <= 3 * MS + 2 * CHAR + 4), 34'h1);
    rd(BRK_ADDR, 34'h0);
    $display("timed break test done");
    wr(BRK_ADDR, BRK_CONT);
    wait_lvl(tx_break, 1'b1, MS + 4, n);
    repeat (5 * MS) @(posedge aclk);
    check(34'(tx_break), 34'h1);
    rd(BRK_ADDR, 34'(BRK_CONT));
    wr(BRK_ADDR, 16'h0001);
    wait_lvl(tx_break, 1'b0, 2 * MS + 2 * CHAR + 8, n);
    wr(BRK_ADDR, BRK_CONT);
    wait_lvl(tx_break, 1'b1, MS + 4, n);
    wr(BRK_ADDR, 16'h0000);
    repeat (2) @(posedge aclk);
    check(34'(tx_break), 34'h0);
    $display("continuous break test done");
    wr(CFG_ADDR, 16'h0001);
    for (i = 0; i < 2; i++) begin
      wr(PFS_ADDR, i ? 16'h0031 : 16'h000b);
      wr(TAD_ADDR, i ? 16'h000f : 16'h0000);
      tx_active <= 1'b1;
      repeat (10) @(posedge aclk);
      for (n = 0; n < 8 && bit_tick !== 1'b1; n++) @(posedge aclk);
      tx_active <= 1'b0;
      ticks = 0;
      for (n = 0; n < 200; n++) begin
        @(posedge aclk);
        if (xcvr_tx_dir !== 1'b1) break;
        ticks += (bit_tick === 1'b1 && tx_active === 1'b0);
      end
      check(34'(ticks), i ? 34'h0f : 34'h0);
    end
    $display("turnaround test done");
    wrap_up();
  end
endmodule // uart_break_pin_function_ctrl_test

// File: sim/ubpf_monitor.sv
// ubpf_monitor: concurrent checks on break timing and pin mux outputs.
// assumes aw and w are offered together and taken at one edge.
`timescale 1ns/1ns
module ubpf_monitor import ubpf_pkg::*; #(
  parameter int unsigned MS_COUNT = MS_CYCLES // cycles per ms
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic s_axi_wvalid, // write data valid
  input wire logic s_axi_wready, // write data ready
  input wire logic tx_shifting, // char being shifted
  input wire logic [9:0] pin_out, // pin levels
  input wire logic [9:0] pin_oe, // pin enables
  input wire logic tx_break, // break level
  input wire logic xcvr_tx_dir // direction
);
  localparam int MS_B = MS_COUNT + 4;
  logic [9:0] pfs_sh;
  logic [9:0] dir_sh;
  logic [15:0] brk_sh;
  logic [1:0] quiet_cnt;
  logic dir_d1;
  logic dir_d2;
  wire wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire brk_wr = wr && s_axi_awaddr == BRK_ADDR;
  wire quiet = quiet_cnt == 2'h0;
  wire de_lvl = pfs_sh[PFS_POL] ? xcvr_tx_dir : !xcvr_tx_dir;
  wire steady = quiet && xcvr_tx_dir == dir_d1 && dir_d1 == dir_d2;
  always_ff @(posedge aclk) begin
    dir_d1 <= xcvr_tx_dir;
    dir_d2 <= dir_d1;
    if (!aresetn) begin
      pfs_sh <= PFS_RESET;
      dir_sh <= DIR_RESET;
      brk_sh <= BRK_RESET;
      quiet_cnt <= 2'h3;
    end else if (wr) begin
      quiet_cnt <= 2'h3;
      if (s_axi_awaddr == PFS_ADDR) pfs_sh <= s_axi_wdata[9:0];
      if (s_axi_awaddr == DIR_ADDR) dir_sh <= s_axi_wdata[9:0];
      if (brk_wr) brk_sh <= s_axi_wdata[15:0];
    end else if (!quiet) begin
      quiet_cnt <= quiet_cnt - 2'h1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_brk_arm;
    brk_wr && s_axi_wdata[15:0] != 16'h0 && !tx_shifting ##1 !tx_shifting [*2];
  endsequence
  AST_BRK_CONT: assert property (quiet && !wr && brk_sh == BRK_CONT && tx_break |=> tx_break)
    else $error("continuous break dropped");
  AST_BRK_ZERO: assert property (brk_wr && s_axi_wdata[15:0] == 16'h0 |-> ##[1:3] !tx_break)
    else $error("break not ended by zero write");
  AST_BRK_SHIFT: assert property ($rose(tx_break) |-> !$past(tx_shifting))
    else $error("break started during a character");
  AST_BRK_START: assert property (s_brk_arm |-> ##[0:MS_B] tx_break)
    else $error("break start too late");
  AST_OE_GPIO: assert property (quiet |-> pin_oe[1:0] == dir_sh[1:0])
    else $error("gpio direction wrong");
  AST_OE_TOGGLE: assert property (quiet |-> pin_oe[9:8] == (pfs_sh[9:8] | dir_sh[9:8]))
    else $error("toggle pin enable wrong");
  AST_OE_CLK: assert property (quiet |-> pin_oe[6] == (pfs_sh[PFS_CLKEN] | dir_sh[6]))
    else $error("clock pin enable wrong");
  AST_DE_PIN5: assert property (steady && !pfs_sh[PFS_SECSEL] && pfs_sh[PFS_MODE_HI:0] == MODE_DE_TX
    |-> pin_oe[5] && pin_out[5] == de_lvl)
    else $error("pin 5 drive enable wrong");
  AST_DE_PIN7: assert property (steady && pfs_sh[PFS_SECSEL] && pfs_sh[PFS_SEC_HI:PFS_SEC_LO] == SEC_DE_TX
    |-> pin_oe[7] && pin_out[7] == de_lvl)
    else $error("pin 7 drive enable wrong");
endmodule // ubpf_monitor
bind ubpf_top ubpf_monitor #(.MS_COUNT(MS_COUNT)) mon_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .tx_shifting(tx_shifting), .pin_out(pin_out), .pin_oe(pin_oe), .tx_break(tx_break), .xcvr_tx_dir(xcvr_tx_dir));

// File: sim/ubpf_xcvr_model.sv
// ubpf_xcvr_model: external line and transceiver seen at the ten pins.
// assumes undriven pins float to a level the line makes, changing each cycle.
`timescale 1ns/1ns
module ubpf_xcvr_model (
  input wire logic aclk, // clock
  input wire logic [9:0] pin_out, // levels driven by the block
  input wire logic [9:0] pin_oe, // enables from the block
  output logic [9:0] pin_in // wire levels
);
  logic [9:0] line_lvl = 10'h2a5;
  always @(posedge aclk) line_lvl <= {line_lvl[8:0], line_lvl[9] ^ line_lvl[6]};
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & line_lvl);
endmodule // ubpf_xcvr_model
